// *** rtl/csa_params.svh ***
`ifndef CSA_PARAMS_SVH
`define CSA_PARAMS_SVH

// register indices on the management port
`define CSA_ADDR_PHASE 8'h34
`define CSA_ADDR_LOOP  8'h35
`define CSA_ADDR_ALERT 8'h36

// phase indicator field positions
`define CSA_PH_EQUALIZE   10
`define CSA_PH_ABSORB     9
`define CSA_PH_SUSPENDED  8
`define CSA_PH_PRECOND    7
`define CSA_PH_MAIN       6
`define CSA_PH_NTC_PAUSE  5
`define CSA_PH_TIMER_TERM 4
`define CSA_PH_CX_TERM    3
`define CSA_PH_MAXTIME    2
`define CSA_PH_BAT_MISS   1
`define CSA_PH_BAT_SHORT  0
`define CSA_PH_MASK       16'h07FF

// loop indicator field positions
`define CSA_LP_UVCL  3
`define CSA_LP_IIN   2
`define CSA_LP_ICHG  1
`define CSA_LP_VCHG  0
`define CSA_LP_MASK  16'h000F

// threshold alert positions
`define CSA_AL_MEAS_VALID 15
`define CSA_AL_QCOUNT_LO  13
`define CSA_AL_QCOUNT_HI  12
`define CSA_AL_VBAT_LO    11
`define CSA_AL_VBAT_HI    10
`define CSA_AL_VIN_LO     9
`define CSA_AL_VIN_HI     8
`define CSA_AL_VSYS_LO    7
`define CSA_AL_VSYS_HI    6
`define CSA_AL_IIN_HI     5
`define CSA_AL_IBAT_LO    4
`define CSA_AL_DIE_HI     3
`define CSA_AL_BSR_HI     2
`define CSA_AL_NTC_COLD   1
`define CSA_AL_NTC_HOT    0
`define CSA_AL_MASK       16'hBFFF

// reset values
`define CSA_RST_ALERT 16'h0000

`endif

// *** rtl/csa_pkg.sv ***
package csa_pkg;

  // one telemetry sample set, signed 16-bit codes
  typedef struct packed {
    logic signed [15:0] qcount;
    logic signed [15:0] vbat;
    logic signed [15:0] vin;
    logic signed [15:0] vsys;
    logic signed [15:0] iin;
    logic signed [15:0] ibat;
    logic signed [15:0] die_temp;
    logic signed [15:0] bsr;
    logic signed [15:0] ntc_ratio;
  } csa_telem_t;

  // programmed limits, held outside this block
  typedef struct packed {
    logic signed [15:0] qcount_lo;
    logic signed [15:0] qcount_hi;
    logic signed [15:0] vbat_lo;
    logic signed [15:0] vbat_hi;
    logic signed [15:0] vin_lo;
    logic signed [15:0] vin_hi;
    logic signed [15:0] vsys_lo;
    logic signed [15:0] vsys_hi;
    logic signed [15:0] iin_hi;
    logic signed [15:0] ibat_lo;
    logic signed [15:0] die_temp_hi;
    logic signed [15:0] bsr_hi;
    logic signed [15:0] ntc_cold;
    logic signed [15:0] ntc_hot;
  } csa_limits_t;

  // register port request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } csa_req_t;

  typedef enum logic [1:0] {
    CSA_ACC_IDLE,
    CSA_ACC_READ,
    CSA_ACC_WRITE
  } csa_acc_t;

endpackage

// *** rtl/csa_alert_cmp.sv ***
`timescale 1ns/10ps
`include "csa_params.svh"

module csa_alert_cmp (
  // clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  // telemetry and limits
  input  wire csa_pkg::csa_telem_t  telem_i,
  input  wire csa_pkg::csa_limits_t limits_i,
  input  wire logic                 telem_valid_i,
  // one bit per alert, registered
  output logic [15:0]               cond_o
);
  import csa_pkg::*;

  logic [15:0] next_cond;

  // hot limit crossed when ratio falls below it (ratio drops as temp rises)
  always_comb begin
    next_cond = 16'h0000;
    if (telem_valid_i) begin
      next_cond[`CSA_AL_QCOUNT_LO] =
        telem_i.qcount < limits_i.qcount_lo;
      next_cond[`CSA_AL_QCOUNT_HI] =
        telem_i.qcount > limits_i.qcount_hi;
      next_cond[`CSA_AL_VBAT_LO] =
        telem_i.vbat < limits_i.vbat_lo;
      next_cond[`CSA_AL_VBAT_HI] =
        telem_i.vbat > limits_i.vbat_hi;
      next_cond[`CSA_AL_VIN_LO] =
        telem_i.vin < limits_i.vin_lo;
      next_cond[`CSA_AL_VIN_HI] =
        telem_i.vin > limits_i.vin_hi;
      next_cond[`CSA_AL_VSYS_LO] =
        telem_i.vsys < limits_i.vsys_lo;
      next_cond[`CSA_AL_VSYS_HI] =
        telem_i.vsys > limits_i.vsys_hi;
      next_cond[`CSA_AL_IIN_HI] =
        telem_i.iin > limits_i.iin_hi;
      next_cond[`CSA_AL_IBAT_LO] =
        telem_i.ibat < limits_i.ibat_lo;
      next_cond[`CSA_AL_DIE_HI] =
        telem_i.die_temp > limits_i.die_temp_hi;
      next_cond[`CSA_AL_BSR_HI] =
        telem_i.bsr > limits_i.bsr_hi;
      next_cond[`CSA_AL_NTC_COLD] =
        telem_i.ntc_ratio > limits_i.ntc_cold;
      next_cond[`CSA_AL_NTC_HOT] =
        telem_i.ntc_ratio < limits_i.ntc_hot;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cond_o <= 16'h0000;
    end else begin
      cond_o <= next_cond;
    end
  end

endmodule

// *** rtl/csa_regs.sv ***
`timescale 1ns/10ps
`include "csa_params.svh"

// How it works
// - phase register read-only, one-hot, bits 15 to 11 read zero.
// - bits 10..6: equalize, absorb, suspended, precondition, main charging.
// - bits 5..3: thermistor pause, timer termination, C/x termination.
// - bits 2..0: max charge time, missing battery, shorted battery faults.
// - loop register read-only, one-hot, zero outside charging phases.
// - loop bit 3 undervoltage loop, bit 2 input current limit loop.
// - loop bit 1 charge current loop, bit 0 battery voltage loop.
// - an alert bit sets only while its enable mask bit is set.
// - writing zero to an alert bit clears it, unless its condition hits in the same cycle (set wins).
// - alert stays set until cleared by host or its enable drops.
// - bit 15 sets when telemetry results first become valid.
// - bit 13 coulomb count low, bit 12 coulomb count high.
// - bit 11 battery voltage low, bit 10 battery voltage high.
// - bit 9 input voltage low, bit 8 input voltage high.
// - bit 7 system voltage low, bit 6 system voltage high.
// - bit 5 input current high, bit 4 battery current low.
// - bit 3 die temperature high, bit 2 battery resistance high.
// - bit 1 thermistor cold limit, bit 0 thermistor hot limit.

module csa_regs (
  // clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  // management port, from the serial port decoder
  input  wire csa_pkg::csa_req_t    req_i,
  output logic [15:0]               rdata_o,
  output logic                      rvalid_o,
  // charger state machine and loop indications
  input  wire logic [10:0]          phase_i,
  input  wire logic [3:0]           loop_i,
  // telemetry, limits and enable mask
  input  wire csa_pkg::csa_telem_t  telem_i,
  input  wire csa_pkg::csa_limits_t limits_i,
  input  wire logic                 telem_valid_i,
  input  wire logic [15:0]          alert_en_i,
  // alert state for the alert pin logic outside
  output logic [15:0]               alert_o
);
  import csa_pkg::*;

  logic [15:0] phase;
  logic [15:0] loop_ind;
  logic [15:0] alert;
  logic        meas_seen;
  logic [15:0] rdata;
  logic        rvalid;
  logic [15:0] next_phase;
  logic [15:0] next_loop;
  logic [15:0] next_alert;
  logic        next_meas_seen;
  logic [15:0] next_rdata;
  logic        next_rvalid;
  logic [15:0] cond;
  logic [15:0] hit;
  logic [15:0] clr;
  logic        charging;
  csa_acc_t    acc;

  // registered compare so the limit adders stay off the flag path
  csa_alert_cmp csa_alert_cmp_inst (
    .clock_i       (clock_i),
    .rst_i         (rst_i),
    .telem_i       (telem_i),
    .limits_i      (limits_i),
    .telem_valid_i (telem_valid_i),
    .cond_o        (cond)
  );

  always_comb begin
    if (req_i.wr) begin
      acc = CSA_ACC_WRITE;
    end else if (req_i.rd) begin
      acc = CSA_ACC_READ;
    end else begin
      acc = CSA_ACC_IDLE;
    end
  end

  // indicator capture
  always_comb begin
    next_phase = 16'h0000;
    next_loop  = 16'h0000;
    charging   = phase_i[`CSA_PH_EQUALIZE] | phase_i[`CSA_PH_ABSORB] |
                 phase_i[`CSA_PH_PRECOND] | phase_i[`CSA_PH_MAIN];
    // keep only the lowest set bit so a glitchy source stays one-hot
    for (int i = 0; i <= `CSA_PH_EQUALIZE; i++) begin
      if (phase_i[i] && (next_phase == 16'h0000)) begin
        next_phase[i] = 1'b1;
      end
    end
    if (charging) begin
      for (int i = 0; i <= `CSA_LP_UVCL; i++) begin
        if (loop_i[i] && (next_loop == 16'h0000)) begin
          next_loop[i] = 1'b1;
        end
      end
    end
    next_phase = next_phase & `CSA_PH_MASK;
    next_loop  = next_loop & `CSA_LP_MASK;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      phase    <= 16'h0000;
      loop_ind <= 16'h0000;
    end else begin
      phase    <= next_phase;
      loop_ind <= next_loop;
    end
  end

  // alert flags
  always_comb begin
    next_meas_seen = meas_seen | telem_valid_i;
    hit = cond;
    hit[`CSA_AL_MEAS_VALID] = telem_valid_i & ~meas_seen;
    // comparisons inside the compare block
    hit = hit & alert_en_i & `CSA_AL_MASK;
    clr = 16'h0000;
    if ((acc == CSA_ACC_WRITE) && (req_i.addr == `CSA_ADDR_ALERT)) begin
      clr = ~req_i.wdata;
    end
    // set wins over clear, so a persisting condition re-arms at once
    next_alert = ((alert & ~clr) | hit) & alert_en_i;
    next_alert = next_alert & `CSA_AL_MASK;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      alert     <= `CSA_RST_ALERT;
      meas_seen <= 1'b0;
    end else begin
      alert     <= next_alert;
      meas_seen <= next_meas_seen;
    end
  end

  // read port; writes to indicators are ignored
  always_comb begin
    next_rdata  = 16'h0000;
    next_rvalid = 1'b0;
    if (acc == CSA_ACC_READ) begin
      next_rvalid = 1'b1;
      unique case (req_i.addr)
        `CSA_ADDR_PHASE: next_rdata = phase;
        `CSA_ADDR_LOOP:  next_rdata = loop_ind;
        `CSA_ADDR_ALERT: next_rdata = alert;
        default:         next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata  <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign rdata_o  = rdata;
  assign rvalid_o = rvalid;
  assign alert_o  = alert;

endmodule

// *** sim/csa_regs_props.sv ***
`timescale 1ns/10ps
module csa_regs_props (
  // clock and reset
  input wire logic                 clock_i,
  input wire logic                 rst_i,
  // register port
  input wire csa_pkg::csa_req_t    req_i,
  input wire logic [15:0]          rdata_o,
  input wire logic                 rvalid_o,
  // charger side
  input wire logic [10:0]          phase_i,
  input wire logic [3:0]           loop_i,
  input wire csa_pkg::csa_telem_t  telem_i,
  input wire csa_pkg::csa_limits_t limits_i,
  input wire logic                 telem_valid_i,
  input wire logic [15:0]          alert_en_i,
  input wire logic [15:0]          alert_o
);
  import csa_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  function automatic logic [15:0] clr(csa_req_t r);
    return (r.wr && r.addr == 8'h36) ? ~r.wdata : 16'h0000;
  endfunction
  // set latency is loose, so the enable is held a cycle longer
  property p_set(c, e, a);
    c && e ##1 e [*3] |-> a;
  endproperty
  chk_en_gate: assert property (
    (alert_o & ~$past(alert_en_i)) == 16'h0000)
    else $error("alert set while disabled");
  chk_bit14_low: assert property (!alert_o[14])
    else $error("alert bit 14 set");
  chk_phase_hot: assert property (
    rvalid_o && $past(req_i.addr) == 8'h34
    |-> $onehot0(rdata_o) && rdata_o[15:11] == 5'h00)
    else $error("phase read not one-hot");
  chk_loop_idle: assert property (
    rvalid_o && $past(req_i.addr) == 8'h35
    && ($past(phase_i) & 11'h6C0) == 11'h000
    && ($past(phase_i, 2) & 11'h6C0) == 11'h000 |-> rdata_o == 16'h0000)
    else $error("loop bits outside charging");
  chk_alert_hold: assert property (($past(alert_o) & ~alert_o
    & ~clr($past(req_i)) & ~clr($past(req_i, 2)) & $past(alert_en_i)
    & $past(alert_en_i, 2)) == 16'h0000)
    else $error("alert dropped by itself");
  chk_wr_clear: assert property (!telem_valid_i [*3] ##0 req_i.wr
    && req_i.addr == 8'h36 ##1 !telem_valid_i
    |=> (alert_o & ~$past(req_i.wdata, 2)) == 16'h0000)
    else $error("write zero did not clear");
  chk_qhi_set: assert property (p_set(telem_valid_i
    && telem_i.qcount > limits_i.qcount_hi, alert_en_i[12], alert_o[12]))
    else $error("coulomb high alert missing");
  chk_vlo_set: assert property (p_set(telem_valid_i
    && telem_i.vbat < limits_i.vbat_lo, alert_en_i[11], alert_o[11]))
    else $error("battery low alert missing");
  cover property (rvalid_o && rdata_o[15]);
  cover property (req_i.wr && req_i.addr == 8'h36);
  cover property (alert_o == 16'hBFFF);
endmodule
bind csa_regs csa_regs_props csa_regs_props_inst (
  .clock_i(clock_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .phase_i(phase_i), .loop_i(loop_i),
  .telem_i(telem_i), .limits_i(limits_i), .telem_valid_i(telem_valid_i),
  .alert_en_i(alert_en_i), .alert_o(alert_o));

// *** sim/csa_host.sv ***
`timescale 1ns/10ps
module csa_host (
  // clock
  input  wire logic         clock_i,
  // request to the registers
  output csa_pkg::csa_req_t req_o
);
  import csa_pkg::*;
  initial req_o = '0;
  // one-cycle pulse; released addr and wdata are driven inverted, not held
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
    @(posedge clock_i);
    req_o <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clock_i);
    req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

// *** sim/charger_status_alert_regs_test.sv ***
`timescale 1ns/10ps
module charger_status_alert_regs_test;
  import csa_pkg::*;
  logic        clock_i;
  logic        rst_i;
  csa_req_t    req;
  logic [15:0] rdata;
  logic        rvalid;
  logic [10:0] phase;
  logic [3:0]  loop;
  csa_telem_t  telem;
  csa_limits_t limits;
  logic        tvalid;
  logic [15:0] en;
  logic [15:0] alert;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [3:0]  l;
  int          failures;
  int          tests_run;
  int          seed;
  csa_regs csa_regs_inst (.clock_i(clock_i), .rst_i(rst_i), .req_i(req),
    .rdata_o(rdata), .rvalid_o(rvalid), .phase_i(phase), .loop_i(loop),
    .telem_i(telem), .limits_i(limits), .telem_valid_i(tvalid),
    .alert_en_i(en), .alert_o(alert));
  csa_host csa_host_inst (.clock_i(clock_i), .req_o(req));
  task automatic check(input logic [15:0] got, input logic [15:0] want);
    tests_run++;
    if (got !== want) begin
      failures++;
      $display("BAD %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    exp_q.push_back(x);
    csa_host_inst.xfer(1'b0, a, 16'h0000);
  endtask
  task automatic stop_test;
    // a read whose answer never came counts against the run
    if (exp_q.size() != 0) failures++;
    $display("compares %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // sample mid-cycle, where the registered answer has settled
  always @(negedge clock_i) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("BAD %0t: read answer with no request", $time);
      end else begin
        check(rdata, exp_q.pop_front());
      end
    end
  end
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    #50000;
    failures++;
    stop_test;
  end
  initial begin
    seed = 32'h15BE1DA2;
    rst_i = 1'b1;
    {phase, loop, telem, limits, tvalid} = '0;
    en = 16'hFFFF;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      l = 4'($random(seed));
      phase <= 11'h001 << i;
      loop <= l;
      repeat (2) @(posedge clock_i);
      rd(8'h34, 16'h0001 << i);
      rd(8'h35, |(phase & 11'h6C0) ? {12'h000, l & (~l + 4'h1)}
                                   : 16'h0000);
    end
    $display("indicator test done");
    e = {2'b00, 14'($random(seed))} + 16'h0001;
    phase <= 11'h000;
    telem <= {9{e}};
    tvalid <= 1'b1;
    repeat (5) @(posedge clock_i);
    rd(8'h36, 16'h956E);
    telem <= {9{-e}};
    repeat (5) @(posedge clock_i);
    rd(8'h36, 16'hBFFF);
    csa_host_inst.xfer(1'b1, 8'h36, 16'h0000);
    repeat (4) @(posedge clock_i);
    rd(8'h36, 16'h2A91);
    tvalid <= 1'b0;
    repeat (3) @(posedge clock_i);
    csa_host_inst.xfer(1'b1, 8'h36, 16'h2A81);
    csa_host_inst.xfer(1'b1, 8'h34, 16'hFFFF);
    rd(8'h36, 16'h2A81);
    rd(8'h34, 16'h0000);
    rd(8'h50, 16'h0000);
    $display("alert test done");
    // random masks; dropping the mask must wipe the flags
    for (int k = 0; k < 4; k++) begin
      en <= 16'($random(seed));
      tvalid <= 1'b1;
      repeat (5) @(posedge clock_i);
      rd(8'h36, 16'h2A91 & en);
      tvalid <= 1'b0;
      en <= 16'h0000;
      repeat (3) @(posedge clock_i);
      rd(8'h36, 16'h0000);
    end
    $display("mask test done");
    repeat (4) @(posedge clock_i);
    stop_test;
  end
endmodule
